// File: inc/lvic_pkg.sv
// Purpose: Constants and types for the interrupt and low-voltage detect block.
// Assumes: Eight-bit registers reached by index over the core's data port.
package lvic_pkg;

  localparam logic [2:0] REG_LOW_VOLTAGE_DETECT_CONTROL = 3'h0, REG_EXTERNAL_EDGE_SELECT = 3'h1, REG_PRIMARY_INTERRUPT_CONTROL_0 = 3'h2,
    REG_PRIMARY_INTERRUPT_CONTROL_1 = 3'h3, REG_PRIMARY_INTERRUPT_CONTROL_2 = 3'h4, REG_MULTI_SOURCE_INTERRUPT_0 = 3'h5, REG_MULTI_SOURCE_INTERRUPT_1 = 3'h6, REG_MULTI_SOURCE_INTERRUPT_2 = 3'h7;
  localparam int NUM_REGS = 8;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] WMASK [NUM_REGS] = '{8'h17, 8'h0f, 8'h7f, 8'hff,
                                               8'hff, 8'h33, 8'hff, 8'h33};

  localparam int LOW_SUPPLY_OUTPUT_FLAG_BIT = 5, SUPPLY_DETECTOR_ENABLE_BIT = 4, VLVD_LSB = 0;
  localparam int INT1S_LSB = 2, INT0S_LSB = 0;
  localparam int EDGE_RISE_BIT = 0, EDGE_FALL_BIT = 1;
  localparam int EMI_BIT = 0, INT0E_BIT = 1, CPE_BIT = 2, MF0E_BIT = 3,
    INT0F_BIT = 4, CPF_BIT = 5, MF0F_BIT = 6;
  localparam int MF1E_BIT = 0, MF2E_BIT = 1, ADE_BIT = 2, TB0E_BIT = 3,
    MF1F_BIT = 4, MF2F_BIT = 5, ADF_BIT = 6, TB0F_BIT = 7;
  localparam int TB1E_BIT = 0, INT1E_BIT = 1, SIME_BIT = 2, URE_BIT = 3,
    TB1F_BIT = 4, INT1F_BIT = 5, SIMF_BIT = 6, URF_BIT = 7;
  localparam int STMPF_BIT = 4, STMAF_BIT = 5;
  localparam int PTMPF_BIT = 4, PTMAF_BIT = 5, CTMPF_BIT = 6, CTMAF_BIT = 7;
  localparam int LVE_BIT = 0, LVF_BIT = 4, DEF_BIT = 5;

  // Primary sources in falling priority; index 0 is serviced first.
  localparam int NUM_PRI = 11;
  localparam logic [2:0] PRI_REG [NUM_PRI] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
                                               3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
  localparam logic [2:0] PRI_FBIT [NUM_PRI] = '{3'h4, 3'h5, 3'h6, 3'h4, 3'h5, 3'h6,
                                                3'h7, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [2:0] PRI_EBIT [NUM_PRI] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2,
                                                3'h3, 3'h0, 3'h1, 3'h2, 3'h3};

  localparam int CLK_PERIOD_NS = 10;
  localparam int LVD_DELAY_NS = 15000;
  localparam int LVD_DELAY_CYC = (LVD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic cmp;
    logic adc;
    logic tb0;
    logic tb1;
    logic sim;
    logic uart;
    logic stm_a;
    logic stm_p;
    logic ctm_a;
    logic ctm_p;
    logic ptm_a;
    logic ptm_p;
    logic eeprom;
  } lvic_evt_s;

endpackage : lvic_pkg

// File: design/lvic_top.sv
// Purpose: Interrupt flags, enables, pin edge detect and supply detector control.
// Assumes: Peripheral event inputs are one-cycle pulses on i_clk_sys.
// Notes: Register reads return data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module lvic_top #(
  parameter int unsigned DELAY_CYC = lvic_pkg::LVD_DELAY_CYC
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rstn,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  input  wire logic [2:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic [1:0]          i_ext_irq_pin,
  input  wire logic                i_supply_below,
  input  wire lvic_pkg::lvic_evt_s i_evt,
  input  wire logic                i_irq_ack,
  output logic [7:0]               o_reg_rdata,
  output logic                     o_irq_req,
  output logic [3:0]               o_irq_vector,
  output logic                     o_wake_request,
  output logic                     o_supply_detector_enable,
  output logic [2:0]               o_supply_threshold_select
);

  localparam logic [12:0] DLY_LAST = 13'(DELAY_CYC - 1);
  localparam logic [12:0] DLY_DONE = 13'(DELAY_CYC);

  logic [7:0]  reg_r [lvic_pkg::NUM_REGS];
  logic [7:0]  set_v [lvic_pkg::NUM_REGS];
  logic [7:0]  clr_v [lvic_pkg::NUM_REGS];
  logic [1:0]  pin_meta_r;
  logic [1:0]  pin_sync_r;
  logic [1:0]  pin_prev_r;
  logic [1:0]  edge_hit;
  logic        cmp_meta_r;
  logic        cmp_sync_r;
  logic        low_supply_output_flag_r;
  logic [12:0] dly_cnt_r;
  logic        lvf_set;
  logic [lvic_pkg::NUM_PRI-1:0] pend;
  logic [3:0]  vec_nxt;
  logic        any_pend;
  logic [7:0]  rd_val;

  function automatic logic mf_pend(input logic [7:0] r);
    mf_pend = |(r[7:4] & r[3:0]);
  endfunction : mf_pend

  // Both pins pass two flops before the edge logic sees them.
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_pin
      logic [1:0] field;
      assign field = (gp == 0) ? reg_r[lvic_pkg::REG_EXTERNAL_EDGE_SELECT][lvic_pkg::INT0S_LSB +: 2]
                               : reg_r[lvic_pkg::REG_EXTERNAL_EDGE_SELECT][lvic_pkg::INT1S_LSB +: 2];
      always_ff @(posedge i_clk_sys or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          pin_meta_r[gp] <= 1'h0;
          pin_sync_r[gp] <= 1'h0;
          pin_prev_r[gp] <= 1'h0;
        end
        else
        begin
          pin_meta_r[gp] <= i_ext_irq_pin[gp];
          pin_sync_r[gp] <= pin_meta_r[gp];
          pin_prev_r[gp] <= pin_sync_r[gp];
        end
      end
      // A single compare of sync against prev gives one hit per transition.
      assign edge_hit[gp] =
        (field[lvic_pkg::EDGE_RISE_BIT] & pin_sync_r[gp] & ~pin_prev_r[gp]) |
        (field[lvic_pkg::EDGE_FALL_BIT] & ~pin_sync_r[gp] & pin_prev_r[gp]);
    end
  endgenerate

  // The comparator is asynchronous to the system clock.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cmp_meta_r <= 1'h0;
      cmp_sync_r <= 1'h0;
    end
    else
    begin
      cmp_meta_r <= i_supply_below;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // No power-mode input gates this path, so the detector runs in any mode.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      low_supply_output_flag_r <= 1'h0;
    else
      low_supply_output_flag_r <= o_supply_detector_enable & cmp_sync_r;
  end

  // Any drop of the flag restarts the delay, so chatter cannot raise a request early.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      dly_cnt_r <= 13'h0000;
    else if (!low_supply_output_flag_r)
      dly_cnt_r <= 13'h0000;
    else if (dly_cnt_r != DLY_DONE)
      dly_cnt_r <= dly_cnt_r + 13'h0001;
  end

  assign lvf_set = low_supply_output_flag_r && (dly_cnt_r == DLY_LAST);

  // Wake only on a fresh request, so a flag set ahead of sleep masks it.
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      o_wake_request <= 1'h0;
    else
      o_wake_request <= lvf_set & ~reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2][lvic_pkg::LVF_BIT];
  end

  genvar gi;
  generate
    for (gi = 0; gi < lvic_pkg::NUM_PRI; gi++)
    begin : g_pend
      assign pend[gi] = reg_r[lvic_pkg::PRI_REG[gi]][lvic_pkg::PRI_FBIT[gi]] &
                        reg_r[lvic_pkg::PRI_REG[gi]][lvic_pkg::PRI_EBIT[gi]];
    end
  endgenerate

  always_comb
  begin
    vec_nxt = 4'h0;
    for (int k = lvic_pkg::NUM_PRI - 1; k >= 0; k--)
    begin
      if (pend[k])
        vec_nxt = 4'(k);
    end
  end

  assign any_pend = |pend;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq_req    <= 1'h0;
      o_irq_vector <= 4'h0;
    end
    else
    begin
      o_irq_req    <= any_pend & reg_r[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::EMI_BIT] &
                      ~i_irq_ack;
      o_irq_vector <= vec_nxt;
    end
  end

  // Hardware sets for registers 2 to 7; acknowledge clears EMI and the serviced flag only.
  always_comb
  begin
    for (int r = 0; r < lvic_pkg::NUM_REGS; r++)
    begin
      set_v[r] = 8'h00;
      clr_v[r] = 8'h00;
    end
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::INT0F_BIT] = edge_hit[0];
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::CPF_BIT]   = i_evt.cmp;
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::MF0F_BIT]  = mf_pend(reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_0]);
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_1][lvic_pkg::MF1F_BIT]  = mf_pend(reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_1]);
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_1][lvic_pkg::MF2F_BIT]  = mf_pend(reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2]);
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_1][lvic_pkg::ADF_BIT]   = i_evt.adc;
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_1][lvic_pkg::TB0F_BIT]  = i_evt.tb0;
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_2][lvic_pkg::TB1F_BIT]  = i_evt.tb1;
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_2][lvic_pkg::INT1F_BIT] = edge_hit[1];
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_2][lvic_pkg::SIMF_BIT]  = i_evt.sim;
    set_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_2][lvic_pkg::URF_BIT]   = i_evt.uart;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_0][lvic_pkg::STMPF_BIT]  = i_evt.stm_p;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_0][lvic_pkg::STMAF_BIT]  = i_evt.stm_a;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_1][lvic_pkg::PTMPF_BIT]  = i_evt.ptm_p;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_1][lvic_pkg::PTMAF_BIT]  = i_evt.ptm_a;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_1][lvic_pkg::CTMPF_BIT]  = i_evt.ctm_p;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_1][lvic_pkg::CTMAF_BIT]  = i_evt.ctm_a;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2][lvic_pkg::LVF_BIT]    = lvf_set;
    set_v[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2][lvic_pkg::DEF_BIT]    = i_evt.eeprom;
    clr_v[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::EMI_BIT]   = i_irq_ack;
    clr_v[lvic_pkg::PRI_REG[o_irq_vector]][lvic_pkg::PRI_FBIT[o_irq_vector]] = i_irq_ack;
  end

  // A hardware set wins over a write or an acknowledge in the same cycle.
  genvar gr;
  generate
    for (gr = 0; gr < lvic_pkg::NUM_REGS; gr++)
    begin : g_reg
      always_ff @(posedge i_clk_sys or negedge i_rstn)
      begin
        if (!i_rstn)
          reg_r[gr] <= lvic_pkg::RESET_VAL;
        else if (i_reg_wr && (i_reg_addr == 3'(gr)))
          reg_r[gr] <= (i_reg_wdata & lvic_pkg::WMASK[gr]) | set_v[gr];
        else
          reg_r[gr] <= (reg_r[gr] & ~clr_v[gr]) | set_v[gr];
      end
    end
  endgenerate

  // Unimplemented bits are never stored, so they read as zero.
  always_comb
  begin
    rd_val = reg_r[i_reg_addr];
    if (i_reg_addr == lvic_pkg::REG_LOW_VOLTAGE_DETECT_CONTROL)
      rd_val[lvic_pkg::LOW_SUPPLY_OUTPUT_FLAG_BIT] = low_supply_output_flag_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      o_reg_rdata <= rd_val;
  end

  assign o_supply_detector_enable  = reg_r[lvic_pkg::REG_LOW_VOLTAGE_DETECT_CONTROL][lvic_pkg::SUPPLY_DETECTOR_ENABLE_BIT];
  assign o_supply_threshold_select = reg_r[lvic_pkg::REG_LOW_VOLTAGE_DETECT_CONTROL][lvic_pkg::VLVD_LSB +: 3];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence s_low_seen;
    o_supply_detector_enable && cmp_sync_r;
  endsequence

  sequence s_pin0_rise;
    reg_r[lvic_pkg::REG_EXTERNAL_EDGE_SELECT][1:0] == 2'h1 && pin_sync_r[0] && !pin_prev_r[0];
  endsequence

  sequence s_ack;
    i_irq_ack;
  endsequence

  property p_low_supply_output_flag_follow;
    s_low_seen |=> low_supply_output_flag_r;
  endproperty
  a_low_supply_output_flag_follow: assert property (p_low_supply_output_flag_follow) else $error("low flag missed");

  property p_lvd_off;
    !o_supply_detector_enable |=> !low_supply_output_flag_r;
  endproperty
  a_lvd_off: assert property (p_lvd_off) else $error("flag high while off");

  property p_lvf_delay;
    lvf_set |-> low_supply_output_flag_r && dly_cnt_r == DLY_LAST;
  endproperty
  a_lvf_delay: assert property (p_lvf_delay) else $error("request before delay");

  property p_lvf_flag;
    lvf_set |=> reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2][lvic_pkg::LVF_BIT];
  endproperty
  a_lvf_flag: assert property (p_lvf_flag) else $error("request flag not set");

  property p_wake;
    lvf_set && !reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2][lvic_pkg::LVF_BIT] |=> o_wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");

  property p_pin0_edge;
    s_pin0_rise |=> reg_r[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::INT0F_BIT];
  endproperty
  a_pin0_edge: assert property (p_pin0_edge) else $error("rising edge lost");

  property p_pin1_off;
    reg_r[lvic_pkg::REG_EXTERNAL_EDGE_SELECT][3:2] == 2'h0 |-> !edge_hit[1];
  endproperty
  a_pin1_off: assert property (p_pin1_off) else $error("disabled pin fired");

  property p_external_edge_select_zero;
    i_reg_rd && i_reg_addr == lvic_pkg::REG_EXTERNAL_EDGE_SELECT |=> o_reg_rdata[7:4] == 4'h0;
  endproperty
  a_external_edge_select_zero: assert property (p_external_edge_select_zero) else $error("upper bits not zero");

  property p_emi_block;
    !reg_r[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::EMI_BIT] |=> !o_irq_req;
  endproperty
  a_emi_block: assert property (p_emi_block) else $error("request with global off");

  property p_ack_clear;
    s_ack ##1 !(i_reg_wr && i_reg_addr == lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0) |->
      !reg_r[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_0][lvic_pkg::EMI_BIT];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("global enable kept");

  property p_mf2_sum;
    mf_pend(reg_r[lvic_pkg::REG_MULTI_SOURCE_INTERRUPT_2]) |=> reg_r[lvic_pkg::REG_PRIMARY_INTERRUPT_CONTROL_1][lvic_pkg::MF2F_BIT];
  endproperty
  a_mf2_sum: assert property (p_mf2_sum) else $error("summary flag missed");

  property p_req_cause;
    o_irq_req |-> $past(any_pend) ##1 1'b1;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without source");

endmodule : lvic_top

`default_nettype wire

// File: tb/lvic_far_side.sv
// Purpose: Far side of the block: external interrupt pins and supply comparator.
// Assumes: Pins and comparator are plain levels, changed between clock edges.
// Notes: The bench moves them through the two tasks below.
`timescale 1ns/100ps
`default_nettype none

module lvic_far_side (
  output var logic [1:0] o_ext_irq_pin,
  output var logic       o_supply_below
);
  initial
  begin
    o_ext_irq_pin  = 2'h0;
    o_supply_below = 1'b0;
  end

  task automatic drive_pin(input int idx, input logic lvl);
    o_ext_irq_pin[idx] = lvl;
  endtask : drive_pin

  // A real comparator chatters near its trip point, so short bursts are allowed.
  task automatic drive_supply(input logic lvl);
    o_supply_below = lvl;
  endtask : drive_supply
endmodule : lvic_far_side

`default_nettype wire

// File: tb/test_lvic_top.sv
// Purpose: Self-checking bench for the interrupt and supply detector block.
// Assumes: Detector delay shortened to four cycles.
// Notes: Pin and comparator levels come from the far side model.
`timescale 1ns/100ps
`default_nettype none

module test_lvic_top;
  localparam int DC = 4;
  logic                i_clk_sys = 1'b0;
  logic                i_rstn    = 1'b0;
  logic                wr = 1'b0, rd = 1'b0, ack = 1'b0;
  logic [2:0]          addr  = 3'h0;
  logic [7:0]          wdata = 8'h00, rdata, v;
  logic [1:0]          pin;
  logic                below, irq, wake, den;
  logic [3:0]          vec;
  logic [2:0]          thr;
  lvic_pkg::lvic_evt_s evt = '0;
  int                  bad_count = 0, compares = 0, wakes = 0, k;

  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (wake === 1'b1) wakes++;

  lvic_far_side i_far (.o_ext_irq_pin(pin), .o_supply_below(below));

  lvic_top #(.DELAY_CYC(DC)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_ext_irq_pin(pin),
    .i_supply_below(below), .i_evt(evt), .i_irq_ack(ack), .o_reg_rdata(rdata),
    .o_irq_req(irq), .o_irq_vector(vec), .o_wake_request(wake),
    .o_supply_detector_enable(den), .o_supply_threshold_select(thr));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    step();
    wr = 1'b1; addr = a; wdata = d;
    step();
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a);
    step();
    rd = 1'b1; addr = a;
    step();
    rd = 1'b0;
    v = rdata;
  endtask : rd_reg

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic t_reset_and_masks();
    logic [7:0] m [8];
    m = '{8'h17, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'h33};
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(3'(i));
      check(v, 8'h00, "reset value");
      wr_reg(3'(i), 8'hff);
      rd_reg(3'(i));
      check(v, m[i], "writable bits");
      if (i == 0) check({4'h0, den, thr}, 8'h0f, "threshold and enable");
      wr_reg(3'(i), 8'h00);
    end
    // Summary flags latched while the sub-source registers had all writable bits set stay set; drop them.
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h00);
  endtask : t_reset_and_masks

  // Each pin and each edge mode: a rise, then a fall without clearing the flag.
  task automatic t_edges();
    logic [2:0] fr;
    int         fb;
    for (int p = 0; p < 2; p++)
      for (int md = 0; md < 4; md++)
      begin
        fr = (p == 0) ? 3'h2 : 3'h4;
        fb = (p == 0) ? 4 : 5;
        wr_reg(3'h1, 8'(md << (2 * p)));
        wr_reg(fr, 8'h00);
        i_far.drive_pin(p, 1'b1);
        step(6);
        rd_reg(fr);
        check(8'(v[fb]), 8'(md & 1), "rising edge flag");
        i_far.drive_pin(p, 1'b0);
        step(6);
        rd_reg(fr);
        check(8'(v[fb]), 8'((md | (md >> 1)) & 1), "falling edge flag");
      end
  endtask : t_edges

  task automatic t_detector();
    wr_reg(3'h7, 8'h01);
    wr_reg(3'h3, 8'h02);
    wr_reg(3'h0, 8'h13);
    check({4'h0, den, thr}, 8'h0b, "detector outputs");
    i_far.drive_supply(1'b1);
    for (k = 1; k < 50 && wake !== 1'b1; k++) step();
    if (k == 50)
    begin
      bad_count++;
      finish_test();
    end
    check(8'(k - 1), 8'(DC + 3), "request delay");
    rd_reg(3'h7);
    check(v, 8'h11, "detector request flag");
    rd_reg(3'h0);
    check(v, 8'h33, "low supply flag");
    rd_reg(3'h3);
    check(v, 8'h22, "summary flag");
    wr_reg(3'h2, 8'h01);
    step(2);
    check({3'h0, irq, vec}, 8'h14, "request and vector");
    ack = 1'b1;
    step();
    ack = 1'b0;
    step();
    check(8'(irq), 8'h00, "request after service");
    rd_reg(3'h2);
    check(v, 8'h00, "global enable cleared");
    i_far.drive_supply(1'b0);
    step(5);
    wr_reg(3'h7, 8'h01);
    i_far.drive_supply(1'b1);
    step(DC - 1);
    i_far.drive_supply(1'b0);
    step(8);
    rd_reg(3'h7);
    check(v, 8'h01, "short low pulse ignored");
    wr_reg(3'h7, 8'h11);
    i_far.drive_supply(1'b1);
    step(DC + 6);
    check(8'(wakes), 8'h01, "wake only once");
    i_far.drive_supply(1'b0);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h7, 8'h00);
  endtask : t_detector

  task automatic t_global();
    wr_reg(3'h3, 8'h04);
    evt.adc = 1'b1;
    step();
    evt.adc = 1'b0;
    step(3);
    check(8'(irq), 8'h00, "no request without global enable");
    rd_reg(3'h3);
    check(v, 8'h44, "flag recorded");
    wr_reg(3'h2, 8'h01);
    step(2);
    check({3'h0, irq, vec}, 8'h15, "converter vector");
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h5, 8'h01);
    evt.stm_p = 1'b1;
    evt.cmp   = 1'b1;
    step();
    evt.stm_p = 1'b0;
    evt.cmp   = 1'b0;
    step(3);
    rd_reg(3'h5);
    check(v, 8'h11, "sub-source flag");
    rd_reg(3'h2);
    check(v, 8'h60, "summary 0 and comparator flags");
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h2, 8'h00);
  endtask : t_global

  initial
  begin
    step(6);
    i_rstn = 1'b1;
    t_reset_and_masks();
    t_edges();
    t_detector();
    t_global();
    finish_test();
  end
endmodule : test_lvic_top

`default_nettype wire
